//--- bench/digitizer_config_and_arm_regs_test.sv
module digitizer_config_and_arm_regs_test;
    timeunit 1ns / 1ns;
    localparam logic [55:0] PAT = 56'hA53C96E15AC35A;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1;
    logic        i_wr, i_rd, o_abort; // strobes
    logic [6:0]  i_addr;              // offset
    logic [7:0]  i_wdata, o_rdata, q = '0;
    logic [11:0] v = '0;              // pulses low, levels high
    wire  [46:0] c;                   // outputs by chain bit
    int          mismatches = 0, checks_done = 0;
    host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
    digitizer_regs dut (.*, .i_initiate(v[0]), .i_ext_arm(v[1]),
        .i_delay_elapsed(v[2]), .i_ref_tick(v[3]),
        .i_prearm_reached(v[4]), .i_final_arm(v[5]),
        .i_first_reading(v[6]), .i_last_reading(v[7]),
        .i_arm_hold(v[8]), .i_delay_pending(v[9]), .i_dual_rate(v[10]),
        .i_prearm_mode(v[11]), .o_sync_out_one_en(c[0]),
        .o_sync_out_two_en(c[1]), .o_ext_in_one_en(c[2]),
        .o_ext_in_two_en(c[3]), .o_cal_source_sel_lo(c[4]),
        .o_cal_source_sel_hi(c[5]), .o_ch_a_impedance_sel(c[6]),
        .o_ch_a_single_ended_en(c[7]), .o_ch_a_load_sel(c[8]),
        .o_ch_a_filter_en(c[9]), .o_ch_a_atten_en(c[10]),
        .o_ch_b_impedance_sel(c[11]), .o_ch_b_single_ended_en(c[12]),
        .o_ch_b_load_sel(c[13]), .o_ch_b_filter_en(c[14]),
        .o_ch_b_atten_en(c[15]), .o_ch_a_cal_addr(c[19:16]),
        .o_ch_a_cal_en(c[20]), .o_ch_b_cal_addr(c[23:21]),
        .o_ch_a_pos_cal_route(c[32]), .o_ch_a_neg_cal_route(c[33]),
        .o_ch_a_input_atten_off(c[34]), .o_ch_a_post_atten_off(c[35]),
        .o_ch_a_diff_disable(c[36]), .o_ch_a_internal_atten_off(c[37]),
        .o_ch_a_internal14_off(c[38]), .o_ch_b_pos_cal_route(c[40]),
        .o_ch_b_neg_cal_route(c[41]), .o_ch_b_input_atten_off(c[42]),
        .o_ch_b_post_atten_off(c[43]), .o_ch_b_diff_disable(c[44]),
        .o_ch_b_internal_atten_off(c[45]), .o_ch_b_internal14_off(c[46]));
    always #50 i_clk = ~i_clk;
    task automatic chk(input logic [37:0] s, input logic [37:0] x);
        checks_done++;
        mismatches += (s !== x);
        if (s !== x)
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, x);
    endtask : chk
    task automatic pf(input logic [11:0] m, input logic [7:0] x);
        v = v | m;
        @(posedge i_clk);
        #1 v[7:0] = 8'h00; // events last one cycle
        host.rd(7'h43, q);
        chk(q, x);
    endtask : pf
    task automatic lv(input logic [3:0] l);
        v[11:8] = l; // levels change one edge ahead of the next event
        @(posedge i_clk);
        #1;
    endtask : lv
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (16) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        for (int n = 0; n < 30 && q !== 8'h19; n++)
            host.rd(7'h43, q); // bounded wait for idle
        chk(q, 8'h19);
        for (int i = 55; i >= 0; i--)
            host.wr(7'h05, {7'h00, PAT[i]});
        host.wr(7'h0B, 8'h04);
        chk({c[46:40], c[38:32], c[23:0]},
            {PAT[46:40], PAT[38:32], PAT[23:0]});
        host.rd(7'h03, q);
        chk(q, {7'h00, PAT[55]});
        for (int i = 55; i >= 0; i--)
        begin
            host.rd(7'h05, q);
            chk(q, {7'h00, PAT[i]});
        end
        host.wr(7'h05, 8'hFE);
        host.wr(7'h0B, 8'hFB);
        chk({c[46:40], c[38:32], c[23:0]},
            {PAT[46:40], PAT[38:32], PAT[23:0]});
        host.wr(7'h0B, 8'h04);
        chk({c[46:40], c[38:32], c[23:0]},
            {PAT[45:39], PAT[37:31], PAT[22:0], 1'b0});
        pf(12'h201, 8'h1A);
        pf(12'h002, 8'hD8);
        pf(12'h024, 8'h4C);
        pf(12'h040, 8'h44);
        pf(12'h080, 8'h59);
        pf(12'h801, 8'h3A);
        pf(12'h010, 8'h1A);
        host.rd(7'h41, q);
        pf(12'h000, 8'h98);
        host.wr(7'h41, 8'hA5);
        chk(o_abort, 1'b1);
        pf(12'h000, 8'h19);
        chk(o_abort, 1'b0);
        i_ce = 1'b0;
        v[0] = 1'b1;
        @(posedge i_clk);
        #1 v[0] = 1'b0;
        i_ce = 1'b1;
        host.rd(7'h43, q);
        chk(q, 8'h19);
        lv(4'h4);
        pf(12'h001, 8'h1A);
        host.rd(7'h41, q);
        chk(q, 8'h00);
        pf(12'h000, 8'h98);
        pf(12'h008, 8'h1C);
        pf(12'h040, 8'h14);
        pf(12'h080, 8'h1A);
        lv(4'h5);
        pf(12'h002, 8'h1A);
        lv(4'h0);
        host.rd(7'h41, q);
        pf(12'h000, 8'h1C);
        pf(12'h040, 8'h14);
        pf(12'h020, 8'h04);
        pf(12'h080, 8'h19);
        give_verdict();
    end
endmodule : digitizer_config_and_arm_regs_test

//--- bench/host_model.sv
module host_model
(
    input  wire logic       i_clk,   // clock
    input  wire logic [7:0] i_rdata, // read data
    output logic      [6:0] o_addr,  // offset
    output logic            o_wr,    // write
    output logic            o_rd,    // read
    output logic      [7:0] o_wdata  // data
);
    timeunit 1ns / 1ns;
    initial {o_addr, o_wr, o_rd, o_wdata} = '0;
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1 {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
        @(posedge i_clk);
        #1 {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0}; // no stale value
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        @(posedge i_clk);
        #1 {o_addr, o_rd} = {a, 1'b1};
        @(posedge i_clk);
        #1 {o_addr, o_rd} = {~a, 1'b0};
        @(posedge i_clk);
        #1 q = i_rdata; // safe one edge after the take
    endtask : rd
endmodule : host_model

//--- design/config_chain.sv
module config_chain
    import digitizer_cfg_pkg::*;
(
    input  wire logic                 i_clk,     // system clock
    input  wire logic                 i_rst_n,   // synchronised reset
    input  wire logic                 i_ce,      // clock enable
    input  wire logic                 i_load,    // shift a new bit in
    input  wire logic                 i_bit,     // bit to shift in
    input  wire logic                 i_unload,  // shift one bit out
    output logic      [CHAIN_LEN-1:0] o_chain    // chain contents
);

    typedef struct packed {
        logic [CHAIN_LEN-1:0] bits; // serial configuration chain
    } chain_type;

    chain_type st;      // registered chain
    chain_type next_st; // next chain

    // write enters at position 0; read rotates the output bit back in,
    // so a full read-back of 56 bits leaves the chain as it was
    always_comb
    begin
        next_st = st;
        if (i_load)
        begin
            next_st.bits = {st.bits[CHAIN_LEN-2:0], i_bit};
        end
        else if (i_unload)
        begin
            next_st.bits = {st.bits[CHAIN_LEN-2:0],
                            st.bits[CHAIN_OUT]};
        end
    end

    // chain register, frozen while the enable is low
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st.bits <= CHAIN_RESET;
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    assign o_chain = st.bits;

    chain_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_load) |=> o_chain == {$past(o_chain[CHAIN_LEN-2:0]),
                                         $past(i_bit)})
        else $error("chain write did not insert bit at position 0");

endmodule : config_chain

//--- design/digitizer_regs.sv
module digitizer_regs
    import digitizer_cfg_pkg::*;
(
    input  wire logic       i_clk,                   // 10 MHz clock
    input  wire logic       i_reset_n,               // async reset, low
    input  wire logic       i_ce,                    // clock enable
    input  wire logic [6:0] i_addr,                  // register offset
    input  wire logic       i_wr,                    // write strobe
    input  wire logic       i_rd,                    // read strobe
    input  wire logic [7:0] i_wdata,                 // write data
    output logic      [7:0] o_rdata,                 // read data, next cycle
    input  wire logic       i_initiate,              // initiate pulse
    input  wire logic       i_ext_arm,               // arm from other source
    input  wire logic       i_arm_hold,              // refuse external arms
    input  wire logic       i_delay_pending,         // arm delay programmed
    input  wire logic       i_delay_elapsed,         // arm delay done pulse
    input  wire logic       i_dual_rate,             // dual rate sampling
    input  wire logic       i_ref_tick,              // reference period pulse
    input  wire logic       i_prearm_mode,           // pre/post arm enabled
    input  wire logic       i_prearm_reached,        // pre-arm count reached
    input  wire logic       i_final_arm,             // last arm count reached
    input  wire logic       i_first_reading,         // first burst reading
    input  wire logic       i_last_reading,          // last burst reading
    output logic            o_abort,                 // abort pulse
    output logic            o_sync_out_one_en,       // sync output one
    output logic            o_sync_out_two_en,       // sync output two
    output logic            o_ext_in_one_en,         // external input one
    output logic            o_ext_in_two_en,         // external input two
    output logic            o_cal_source_sel_lo,     // cal source low bit
    output logic            o_cal_source_sel_hi,     // cal source high bit
    output logic            o_ch_a_impedance_sel,    // 1 = 75 ohm
    output logic            o_ch_a_single_ended_en,  // single-ended input
    output logic            o_ch_a_load_sel,         // dummy load
    output logic            o_ch_a_filter_en,        // filter
    output logic            o_ch_a_atten_en,         // attenuators
    output logic            o_ch_b_impedance_sel,    // 1 = 75 ohm
    output logic            o_ch_b_single_ended_en,  // single-ended input
    output logic            o_ch_b_load_sel,         // dummy load
    output logic            o_ch_b_filter_en,        // filter
    output logic            o_ch_b_atten_en,         // attenuators
    output logic      [3:0] o_ch_a_cal_addr,         // cal address lines
    output logic            o_ch_a_cal_en,           // cal enable
    output logic      [2:0] o_ch_b_cal_addr,         // cal address lines
    output logic            o_ch_a_pos_cal_route,    // 0 = cal line
    output logic            o_ch_a_neg_cal_route,    // 0 = cal line
    output logic            o_ch_a_input_atten_off,  // 20dB input, low on
    output logic            o_ch_a_post_atten_off,   // 20dB post, low on
    output logic            o_ch_a_diff_disable,     // low = diff enabled
    output logic            o_ch_a_internal_atten_off,  // 6dB, low on
    output logic            o_ch_a_internal14_off,   // 14dB, low on
    output logic            o_ch_b_pos_cal_route,    // 0 = cal line
    output logic            o_ch_b_neg_cal_route,    // 0 = cal line
    output logic            o_ch_b_input_atten_off,  // 20dB input, low on
    output logic            o_ch_b_post_atten_off,   // 20dB post, low on
    output logic            o_ch_b_diff_disable,     // low = diff enabled
    output logic            o_ch_b_internal_atten_off,  // 6dB, low on
    output logic            o_ch_b_internal14_off    // 14dB, low on
);

    logic                 rst_meta;  // reset release, first stage
    logic                 rst_n;     // synchronised reset
    logic [CHAIN_LEN-1:0] chain;     // serial chain contents
    logic                 chain_wr;  // serial port write
    logic                 chain_rd;  // serial port read
    logic                 abort_wr;  // abort register write
    logic                 arm_rd;    // arm immediate read
    logic                 strobe;    // latch request
    logic [7:0]           flags;     // arming flag byte
    core_type             st;        // registered state
    core_type             next_st;   // next state

    // reset asserts at once and releases two edges later
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // decode of the side-effect accesses; write wins if both strobe
    assign chain_wr = i_wr && (i_addr == SERIAL_PORT_OFS);
    assign chain_rd = i_rd && !i_wr && (i_addr == SERIAL_PORT_OFS);
    assign abort_wr = i_wr && (i_addr == ABORT_ARM_OFS);
    assign arm_rd   = i_rd && !i_wr && (i_addr == ABORT_ARM_OFS);
    assign strobe   = i_wr && (i_addr == LATCH_STROBE_OFS)
                      && i_wdata[STROBE_LATCH_BIT];

    // the chain has no address; only the serial port reaches it
    config_chain u_chain (
        .i_clk    (i_clk),
        .i_rst_n  (rst_n),
        .i_ce     (i_ce),
        .i_load   (chain_wr),
        .i_bit    (i_wdata[0]),
        .i_unload (chain_rd),
        .o_chain  (chain)
    );

    // arming flag byte assembled from sequencer state and sticky flags
    always_comb
    begin
        flags                   = 8'h00;
        flags[FLAG_PRE_DELAY]   = (st.seq == SEQ_PRE_DELAY);
        flags[FLAG_EXT_SEEN]    = st.ext_seen;
        flags[FLAG_NO_ARM]      = st.no_arm;
        flags[FLAG_FINAL_N]     = st.final_n;
        flags[FLAG_BEGIN_N]     = st.begin_n;
        flags[FLAG_DELAYED]     = (st.seq == SEQ_WAIT_TRIG)
                                  || (st.seq == SEQ_BURST);
        flags[FLAG_INITIATED]   = (st.seq == SEQ_WAIT_ARM);
        flags[FLAG_INITIALIZED] = (st.seq == SEQ_IDLE);
    end

    // register reads, strobe latch and the arming sequencer
    always_comb
    begin
        next_st       = st;
        next_st.abort = 1'b0;

        // read data is captured on the read strobe and held until the next
        if (i_rd)
        begin
            case (i_addr)
                ADC_STATUS_OFS:  next_st.rdata = {7'h00, chain[CHAIN_OUT]};
                SERIAL_PORT_OFS: next_st.rdata = {7'h00, chain[CHAIN_OUT]};
                ARM_FLAGS_OFS:   next_st.rdata = flags;
                default:         next_st.rdata = 8'h00; // write-only, unmapped
            endcase
        end

        // the top four chain positions are never latched into the configuration
        if (strobe)
        begin
            next_st.cfg = chain[CFG_USED-1:0];
        end

        case (st.seq)
            SEQ_INIT:
            begin
                // hold off arming until the front end has settled
                next_st.init_cnt = st.init_cnt + 5'h01;
                if (st.init_cnt == INIT_CYCLES - 5'h01)
                begin
                    next_st.seq = SEQ_IDLE;
                end
            end
            SEQ_IDLE:
            begin
                if (i_initiate)
                begin
                    next_st.seq      = SEQ_WAIT_ARM;
                    next_st.ext_seen = 1'b0;
                    next_st.no_arm   = i_prearm_mode;
                end
            end
            SEQ_WAIT_ARM:
            begin
                // no arm is refused while pre-arm runs; the host checks
                if (arm_rd || (i_ext_arm && !i_arm_hold))
                begin
                    if (i_delay_pending || (arm_rd && i_dual_rate))
                    begin
                        next_st.seq = SEQ_PRE_DELAY;
                    end
                    else
                    begin
                        next_st.seq = SEQ_WAIT_TRIG;
                    end
                end
            end
            SEQ_PRE_DELAY:
            begin
                // dual rate with no delay waits one reference period
                if (i_delay_pending ? i_delay_elapsed : i_ref_tick)
                begin
                    next_st.seq = SEQ_WAIT_TRIG;
                end
            end
            SEQ_WAIT_TRIG:
            begin
                if (i_first_reading)
                begin
                    next_st.seq     = SEQ_BURST;
                    next_st.begin_n = 1'b0;
                end
            end
            SEQ_BURST:
            begin
                if (i_last_reading)
                begin
                    next_st.begin_n = 1'b1;
                    next_st.final_n = 1'b1;
                    // returning to wait-arm marks the next segment ready
                    next_st.seq = st.final_n ? SEQ_WAIT_ARM
                                             : SEQ_IDLE;
                end
            end
            default:
            begin
                next_st.seq = SEQ_IDLE;
            end
        endcase

        // events placed after the clears so that they win a tie
        if (i_prearm_reached)
        begin
            next_st.no_arm = 1'b0;
        end
        if (i_ext_arm && !i_arm_hold && (st.seq == SEQ_WAIT_ARM))
        begin
            next_st.ext_seen = 1'b1;
        end
        if (i_final_arm && (st.seq != SEQ_IDLE) && (st.seq != SEQ_INIT))
        begin
            next_st.final_n = 1'b0;
        end

        // abort overrides the sequencer, begin_n, final_n and no_arm, except during initialization
        if (abort_wr && (st.seq != SEQ_INIT))
        begin
            next_st.seq     = SEQ_IDLE;
            next_st.abort   = 1'b1;
            next_st.begin_n = 1'b1;
            next_st.final_n = 1'b1;
            next_st.no_arm  = 1'b0;
        end
    end

    // single state register, frozen while the enable is low
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= CORE_RESET;
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    // outputs taken straight from the state register
    assign o_rdata = st.rdata;
    assign o_abort = st.abort;

    assign o_sync_out_one_en      = st.cfg[SYNC_ONE_POS];
    assign o_sync_out_two_en      = st.cfg[SYNC_TWO_POS];
    assign o_ext_in_one_en        = st.cfg[EXT_ONE_POS];
    assign o_ext_in_two_en        = st.cfg[EXT_TWO_POS];
    assign o_cal_source_sel_lo    = st.cfg[CAL_SEL_LO_POS];
    assign o_cal_source_sel_hi    = st.cfg[CAL_SEL_HI_POS];
    assign o_ch_a_impedance_sel   = st.cfg[CH_A_FRONT_POS];
    assign o_ch_a_single_ended_en = st.cfg[CH_A_FRONT_POS+1];
    assign o_ch_a_load_sel        = st.cfg[CH_A_FRONT_POS+2];
    assign o_ch_a_filter_en       = st.cfg[CH_A_FRONT_POS+3];
    assign o_ch_a_atten_en        = st.cfg[CH_A_FRONT_POS+4];
    assign o_ch_b_impedance_sel   = st.cfg[CH_B_FRONT_POS];
    assign o_ch_b_single_ended_en = st.cfg[CH_B_FRONT_POS+1];
    assign o_ch_b_load_sel        = st.cfg[CH_B_FRONT_POS+2];
    assign o_ch_b_filter_en       = st.cfg[CH_B_FRONT_POS+3];
    assign o_ch_b_atten_en        = st.cfg[CH_B_FRONT_POS+4];
    assign o_ch_a_cal_addr = st.cfg[CH_A_CAL_A_POS+3:CH_A_CAL_A_POS];
    assign o_ch_a_cal_en   = st.cfg[CH_A_CAL_EN_POS];
    assign o_ch_b_cal_addr = st.cfg[CH_B_CAL_A_POS+2:CH_B_CAL_A_POS];
    // active-low elements: a zero in the chain engages them
    assign o_ch_a_pos_cal_route      = st.cfg[CH_A_ROUTE_POS];
    assign o_ch_a_neg_cal_route      = st.cfg[CH_A_ROUTE_POS+1];
    assign o_ch_a_input_atten_off    = st.cfg[CH_A_ROUTE_POS+2];
    assign o_ch_a_post_atten_off     = st.cfg[CH_A_ROUTE_POS+3];
    assign o_ch_a_diff_disable       = st.cfg[CH_A_ROUTE_POS+4];
    assign o_ch_a_internal_atten_off = st.cfg[CH_A_ROUTE_POS+5];
    assign o_ch_a_internal14_off     = st.cfg[CH_A_ROUTE_POS+6];
    assign o_ch_b_pos_cal_route      = st.cfg[CH_B_ROUTE_POS];
    assign o_ch_b_neg_cal_route      = st.cfg[CH_B_ROUTE_POS+1];
    assign o_ch_b_input_atten_off    = st.cfg[CH_B_ROUTE_POS+2];
    assign o_ch_b_post_atten_off     = st.cfg[CH_B_ROUTE_POS+3];
    assign o_ch_b_diff_disable       = st.cfg[CH_B_ROUTE_POS+4];
    assign o_ch_b_internal_atten_off = st.cfg[CH_B_ROUTE_POS+5];
    assign o_ch_b_internal14_off     = st.cfg[CH_B_ROUTE_POS+6];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    // arm request taken while waiting for an arm
    sequence s_arm_now;
        i_ce && arm_rd && (st.seq == SEQ_WAIT_ARM);
    endsequence

    sequence s_immediate_path;
        !i_dual_rate && !i_delay_pending;
    endsequence

    strobe_latch_a: assert property (
        (i_ce && strobe) |=> st.cfg == $past(chain[CFG_USED-1:0]))
        else $error("strobe did not latch the chain");

    strobe_hold_a: assert property (
        (i_ce && i_wr && (i_addr == LATCH_STROBE_OFS)
         && !i_wdata[STROBE_LATCH_BIT]) |=> $stable(st.cfg))
        else $error("strobe without bit 2 changed configuration");

    abort_idle_a: assert property (
        (i_ce && abort_wr && (st.seq != SEQ_INIT))
        |=> (st.seq == SEQ_IDLE) && o_abort)
        else $error("abort write did not return to idle");

    arm_now_a: assert property (
        (s_arm_now and s_immediate_path) |=> (st.seq == SEQ_WAIT_TRIG))
        else $error("arm read did not arm the sequencer");

    dual_pre_a: assert property (
        (s_arm_now and (i_dual_rate && !abort_wr))
        |=> (st.seq == SEQ_PRE_DELAY))
        else $error("dual rate arm skipped pre-delay");

    ext_seen_a: assert property (
        (i_ce && i_ext_arm && !i_arm_hold && (st.seq == SEQ_WAIT_ARM))
        |=> st.ext_seen)
        else $error("external arm not flagged");

    final_low_a: assert property (
        (i_ce && i_final_arm && (st.seq == SEQ_BURST) && !abort_wr)
        |=> !st.final_n)
        else $error("final arm flag did not drop");

    serial_read_a: assert property (
        (i_ce && chain_rd)
        |=> (o_rdata == {7'h00, $past(chain[CHAIN_OUT])})
            && (chain[0] == $past(chain[CHAIN_OUT])))
        else $error("serial read did not return and rotate bit 55");

    status_mirror_a: assert property (
        (i_ce && i_rd && !i_wr && (i_addr == ADC_STATUS_OFS))
        |=> (o_rdata[0] == $past(chain[CHAIN_OUT])) && $stable(chain))
        else $error("status read disturbed or missed chain bit 55");

endmodule : digitizer_regs

//--- pkg/digitizer_cfg_pkg.sv
package digitizer_cfg_pkg;

    // register offsets on the byte-wide register port
    localparam logic [6:0] ADC_STATUS_OFS   = 7'h03; // chain output mirror
    localparam logic [6:0] SERIAL_PORT_OFS  = 7'h05; // chain bit in / out
    localparam logic [6:0] LATCH_STROBE_OFS = 7'h0B; // chain to converter
    localparam logic [6:0] ABORT_ARM_OFS    = 7'h41; // write abort, read arm
    localparam logic [6:0] ARM_FLAGS_OFS    = 7'h43; // arming state flags

    // chain geometry: the top four positions carry nothing
    localparam int CHAIN_LEN = 56;
    localparam int CFG_USED  = 52;
    localparam int CHAIN_OUT = 55;

    // strobe register field
    localparam int STROBE_LATCH_BIT = 2;

    // chain field positions
    localparam int SYNC_ONE_POS    = 0;
    localparam int SYNC_TWO_POS    = 1;
    localparam int EXT_ONE_POS     = 2;
    localparam int EXT_TWO_POS     = 3;
    localparam int CAL_SEL_LO_POS  = 4;
    localparam int CAL_SEL_HI_POS  = 5;
    localparam int CH_A_FRONT_POS  = 6;  // impedance..atten, five bits
    localparam int CH_B_FRONT_POS  = 11;
    localparam int CH_A_CAL_A_POS  = 16; // four address lines
    localparam int CH_A_CAL_EN_POS = 20;
    localparam int CH_B_CAL_A_POS  = 21; // three address lines
    localparam int CH_A_ROUTE_POS  = 32; // routes then five active-low bits
    localparam int CH_B_ROUTE_POS  = 40;

    // arming flag positions
    localparam int FLAG_PRE_DELAY   = 7;
    localparam int FLAG_EXT_SEEN    = 6;
    localparam int FLAG_NO_ARM      = 5;
    localparam int FLAG_FINAL_N     = 4;
    localparam int FLAG_BEGIN_N     = 3;
    localparam int FLAG_DELAYED     = 2;
    localparam int FLAG_INITIATED   = 1;
    localparam int FLAG_INITIALIZED = 0;

    // power-up initialization time in clock cycles
    localparam logic [4:0] INIT_CYCLES = 5'h10;

    // arming sequencer states
    typedef enum logic [2:0] {
        SEQ_INIT,
        SEQ_IDLE,
        SEQ_WAIT_ARM,
        SEQ_PRE_DELAY,
        SEQ_WAIT_TRIG,
        SEQ_BURST
    } seq_state_type;

    // whole state of the register bank
    typedef struct packed {
        seq_state_type       seq;      // arming sequencer
        logic [4:0]          init_cnt; // initialization timer
        logic [CFG_USED-1:0] cfg;      // latched converter setup
        logic [7:0]          rdata;    // read data
        logic                ext_seen; // arm from a non-immediate source
        logic                no_arm;   // pre-arm readings running
        logic                final_n;  // low while final burst pending
        logic                begin_n;  // low during a burst
        logic                abort;    // abort pulse
    } core_type;

    localparam core_type CORE_RESET = '{
        seq:      SEQ_INIT,
        init_cnt: 5'h00,
        cfg:      52'h0,
        rdata:    8'h00,
        ext_seen: 1'b0,
        no_arm:   1'b0,
        final_n:  1'b1,
        begin_n:  1'b1,
        abort:    1'b0
    };

    localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = 56'h0;

endpackage : digitizer_cfg_pkg
